// >>> inc/ubs_pkg.sv
// Constants shared by the serial break and stop control block.
// Assumes an 8-bit CPU register port with 16-bit byte addresses.
`default_nettype none
package ubs_pkg;
    // ========================================================================
    // Register addresses.
    localparam logic [15:0] ADDR_PORT4_DIR    = 16'hFF24;
    localparam logic [15:0] ADDR_MODE_CTRL    = 16'hFF90;
    localparam logic [15:0] ADDR_BREAK_LINE   = 16'hFF98;
    localparam logic [15:0] ADDR_INPUT_SWITCH = 16'hFF9C;

    // ========================================================================
    // Reset values.
    localparam logic [7:0] RST_PORT4_DIR    = 8'hFF;
    localparam logic [7:0] RST_MODE_CTRL    = 8'h01;
    localparam logic [7:0] RST_BREAK_LINE   = 8'h16;
    localparam logic [7:0] RST_INPUT_SWITCH = 8'h00;

    // ========================================================================
    // Field positions.
    localparam int MODE_POWER_BIT     = 7;
    localparam int MODE_TX_EN_BIT     = 6;
    localparam int MODE_RX_EN_BIT     = 5;
    localparam int LINE_RX_STATUS_BIT = 7;
    localparam int LINE_RX_TRIG_BIT   = 6;
    localparam int LINE_TX_TRIG_BIT   = 5;
    localparam int LINE_LEN_HI        = 4;
    localparam int LINE_LEN_LO        = 2;
    localparam int LINE_ORDER_BIT     = 1;
    localparam int LINE_INVERT_BIT    = 0;
    localparam int ISC_EXT_IRQ_BIT    = 0;
    localparam int ISC_CAPTURE_BIT    = 1;
    localparam int PORT4_PINS         = 6;
    localparam logic [1:0] PORT4_FIXED_HI = 2'h3;

    // ========================================================================
    // Break field timing in bit times; BAUD_K_DEF is half a bit time in clocks.
    localparam logic [4:0] BRK_LEN_BASE = 5'h0D;
    localparam logic [2:0] BRK_LEN_ROT  = 3'h3;
    localparam logic [4:0] BRK_MIN_BITS = 5'h0B;
    localparam int         BAUD_K_DEF   = 8;

    typedef enum logic [1:0] {RX_IDLE, RX_WAIT_LOW, RX_LOW} ubs_rx_st_t;
    typedef enum logic       {TX_IDLE, TX_LOW} ubs_tx_st_t;
endpackage
`default_nettype wire

// >>> logic/ubs_tick.sv
// Bit-time tick generator for break fields.
// Assumes the run input is held while a field is being timed.
`default_nettype none
module ubs_tick #(
    parameter int K = 8
) (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_run,
    output logic      o_tick
);
    localparam int W = $clog2(2 * K);
    localparam logic [W-1:0] LAST = W'(2 * K - 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } ubs_tick_st_t;

    ubs_tick_st_t s_q;
    ubs_tick_st_t s_d;

    // ========================================================================
    // The bit time is one counter period, so a tick marks every 2K clocks.
    always_comb begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        if (!i_run) begin
            s_d.cnt = '0;
        end else if (s_q.cnt == LAST) begin
            s_d.cnt  = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + W'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_tick = s_q.tick;

    chk_tick_period: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_run && s_q.cnt == LAST) |=> o_tick)
        else $error("bit tick missing after full count");
endmodule
`default_nettype wire

// >>> logic/ubs_ctrl.sv
// Break field, line control and stop control of the serial unit.
// Assumes the frame shifter, baud generator and port latches live outside.
//
// Notes on behaviour
// - Break and line register resets to 16H.
// - Break status reads 1 during reception.
// - Length code selects 13 to 20 bits.
// - Order bit: 0 MSB first, 1 LSB.
// - Invert bit flips transmit line polarity.
// - Receive trigger reads 0, clears on success.
// - Transmit trigger reads 0, clears at end.
// - Reception error keeps status; software retriggers.
// - Switch bits route receive pin onward.
// - Port direction 0 outputs, resets FFH.
// - All three mode bits clear stops unit.
// - Power off stops clock, resets status.
// - Enable clear resets its own circuit.
// - Power off drives line and input high.
// - Mode register resets 01H, holds fields.
// - Breaks are timed by the bit clock.
`default_nettype none
module ubs_ctrl
    import ubs_pkg::*;
#(
    parameter int BAUD_K = ubs_pkg::BAUD_K_DEF
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RESET,
    input  wire logic [15:0] I_ADDR,
    input  wire logic        I_WR,
    input  wire logic [7:0]  I_WDATA,
    input  wire logic        I_RX_PIN,
    input  wire logic        I_SHIFT_TXD,
    input  wire logic        I_EXT_IRQ_PIN,
    input  wire logic        I_CAPTURE_PIN,
    output logic [7:0]       O_RDATA,
    output logic             O_SERIAL_TX_LINE,
    output logic             O_RX_LINE,
    output logic             O_UNIT_CLK_EN,
    output logic             O_UNIT_RESET,
    output logic             O_TX_RUN,
    output logic             O_RX_RUN,
    output logic             O_LSB_FIRST,
    output logic [7:0]       O_MODE,
    output logic             O_TX_COMPLETE_IRQ,
    output logic             O_BREAK_RX_DONE,
    output logic             O_BREAK_RX_ERR,
    output logic             O_EXT_IRQ_IN,
    output logic             O_CAPTURE_IN,
    output logic [5:0]       O_PORT_OE
);
    import ubs_pkg::*;

    typedef struct packed {
        logic [7:0]  mode;
        logic        rx_status;
        logic        rx_trig;
        logic        tx_trig;
        logic [2:0]  brk_len;
        logic        lsb_first;
        logic        tx_inv;
        logic [1:0]  input_switch_control;
        logic [5:0]  port_dir;
        ubs_rx_st_t  rx_st;
        ubs_tx_st_t  tx_st;
        logic [4:0]  rx_cnt;
        logic [4:0]  tx_cnt;
        logic [7:0]  rdata;
        logic        tx_line;
        logic        rx_line;
        logic        clk_en;
        logic        unit_rst;
        logic        tx_run;
        logic        rx_run;
        logic        lsb_out;
        logic        tx_done;
        logic        rx_done;
        logic        rx_err;
        logic        ext_irq;
        logic        capture;
        logic [5:0]  port_oe;
    } ubs_state_t;

    ubs_state_t s_q;
    ubs_state_t s_d;

    logic tx_tick;
    logic rx_tick;
    logic wr_line;
    logic tx_restart;
    logic rx_restart;

    // ========================================================================
    // Helpers.
    function automatic logic [4:0] brk_len_bits(input logic [2:0] code);
        logic [2:0] rot;
        rot = code + BRK_LEN_ROT;
        return BRK_LEN_BASE + {2'b00, rot};
    endfunction

    function automatic logic [4:0] sat_inc(input logic [4:0] v);
        return (v == 5'h1F) ? v : v + 5'h01;
    endfunction

    // ========================================================================
    // Break trigger writes.
    // A trigger is only accepted while its direction is powered and enabled;
    // otherwise there is no clock to time the field with.
    assign wr_line    = I_WR && (I_ADDR == ADDR_BREAK_LINE);
    assign tx_restart = wr_line && I_WDATA[LINE_TX_TRIG_BIT]
                        && s_q.mode[MODE_POWER_BIT]
                        && s_q.mode[MODE_TX_EN_BIT];
    assign rx_restart = wr_line && I_WDATA[LINE_RX_TRIG_BIT]
                        && s_q.mode[MODE_POWER_BIT]
                        && s_q.mode[MODE_RX_EN_BIT];

    ubs_tick #(
        .K       (BAUD_K)
    ) u_tx_tick (
        .i_clk   (I_CLK),
        .i_reset (I_RESET),
        .i_run   ((s_q.tx_st == TX_LOW) && !tx_restart),
        .o_tick  (tx_tick)
    );

    ubs_tick #(
        .K       (BAUD_K)
    ) u_rx_tick (
        .i_clk   (I_CLK),
        .i_reset (I_RESET),
        .i_run   ((s_q.rx_st == RX_LOW) && !rx_restart),
        .o_tick  (rx_tick)
    );

    // ========================================================================
    // Next state.
    always_comb begin
        logic power;
        logic tx_on;
        logic rx_on;
        logic rx_in;
        logic bit_out;
        power   = s_q.mode[MODE_POWER_BIT];
        tx_on   = power && s_q.mode[MODE_TX_EN_BIT];
        rx_on   = power && s_q.mode[MODE_RX_EN_BIT];
        rx_in   = power ? I_RX_PIN : 1'b1;
        bit_out = 1'b1;
        s_d     = s_q;
        s_d.tx_done = 1'b0;
        s_d.rx_done = 1'b0;
        s_d.rx_err  = 1'b0;

        // Register writes.
        if (I_WR) begin
            unique case (I_ADDR)
                ADDR_MODE_CTRL: begin
                    s_d.mode = I_WDATA;
                end
                ADDR_BREAK_LINE: begin
                    s_d.brk_len   = I_WDATA[LINE_LEN_HI:LINE_LEN_LO];
                    s_d.lsb_first = I_WDATA[LINE_ORDER_BIT];
                    s_d.tx_inv    = I_WDATA[LINE_INVERT_BIT];
                end
                ADDR_INPUT_SWITCH: begin
                    s_d.input_switch_control = I_WDATA[ISC_CAPTURE_BIT:ISC_EXT_IRQ_BIT];
                end
                ADDR_PORT4_DIR: begin
                    s_d.port_dir = I_WDATA[PORT4_PINS-1:0];
                end
                default: begin
                end
            endcase
        end

        // Break transmission.
        unique case (s_q.tx_st)
            TX_IDLE: begin
            end
            TX_LOW: begin
                bit_out = 1'b0;
                if (tx_tick) begin
                    if (s_q.tx_cnt == brk_len_bits(s_q.brk_len) - 5'h01) begin
                        s_d.tx_st   = TX_IDLE;
                        s_d.tx_trig = 1'b0;
                        s_d.tx_done = 1'b1;
                    end else begin
                        s_d.tx_cnt = s_q.tx_cnt + 5'h01;
                    end
                end
            end
        endcase
        if (tx_restart) begin
            s_d.tx_st   = TX_LOW;
            s_d.tx_cnt  = '0;
            s_d.tx_trig = 1'b1;
            s_d.tx_done = 1'b0;
        end

        // Break reception; a short low keeps the status set.
        unique case (s_q.rx_st)
            RX_IDLE: begin
            end
            RX_WAIT_LOW: begin
                if (!rx_in) begin
                    s_d.rx_st  = RX_LOW;
                    s_d.rx_cnt = '0;
                end
            end
            RX_LOW: begin
                if (rx_tick) begin
                    s_d.rx_cnt = sat_inc(s_q.rx_cnt);
                end
                if (rx_in) begin
                    s_d.rx_st = RX_IDLE;
                    if (s_q.rx_cnt >= BRK_MIN_BITS) begin
                        s_d.rx_status = 1'b0;
                        s_d.rx_trig   = 1'b0;
                        s_d.rx_done   = 1'b1;
                    end else begin
                        s_d.rx_err = 1'b1;
                    end
                end
            end
            default: begin
                s_d.rx_st = RX_IDLE;
            end
        endcase
        if (rx_restart) begin
            s_d.rx_st     = RX_WAIT_LOW;
            s_d.rx_status = 1'b1;
            s_d.rx_trig   = 1'b1;
            s_d.rx_done   = 1'b0;
            s_d.rx_err    = 1'b0;
        end

        // Enable and power resets override everything above.
        if (!tx_on) begin
            s_d.tx_st   = TX_IDLE;
            s_d.tx_trig = 1'b0;
        end
        if (!rx_on) begin
            s_d.rx_st   = RX_IDLE;
            s_d.rx_trig = 1'b0;
        end
        if (!power) begin
            s_d.rx_status = 1'b0;
            s_d.rx_trig   = 1'b0;
        end

        // Registered outputs.
        if (!power) begin
            s_d.tx_line = 1'b1;
        end else if (tx_on) begin
            s_d.tx_line = (s_q.tx_st == TX_LOW ? bit_out : I_SHIFT_TXD)
                          ^ s_q.tx_inv;
        end else begin
            s_d.tx_line = 1'b1;
        end
        s_d.rx_line  = rx_in;
        s_d.clk_en   = power;
        s_d.unit_rst = !power;
        s_d.tx_run   = tx_on;
        s_d.rx_run   = rx_on;
        s_d.lsb_out  = s_q.lsb_first;
        s_d.ext_irq  = s_q.input_switch_control[ISC_EXT_IRQ_BIT] ? I_RX_PIN
                                                : I_EXT_IRQ_PIN;
        s_d.capture  = s_q.input_switch_control[ISC_CAPTURE_BIT] ? I_RX_PIN
                                                : I_CAPTURE_PIN;
        s_d.port_oe  = ~s_q.port_dir;

        // Reads; both trigger bits always read as zero.
        unique case (I_ADDR)
            ADDR_MODE_CTRL:    s_d.rdata = s_q.mode;
            ADDR_BREAK_LINE:   s_d.rdata = {s_q.rx_status, 2'b00,
                                            s_q.brk_len, s_q.lsb_first,
                                            s_q.tx_inv};
            ADDR_INPUT_SWITCH: s_d.rdata = {6'h00, s_q.input_switch_control};
            ADDR_PORT4_DIR:    s_d.rdata = {PORT4_FIXED_HI,
                                            s_q.port_dir};
            default:           s_d.rdata = 8'h00;
        endcase
    end

    // ========================================================================
    // State register.
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            s_q           <= '0;
            s_q.mode      <= RST_MODE_CTRL;
            s_q.brk_len   <= RST_BREAK_LINE[LINE_LEN_HI:LINE_LEN_LO];
            s_q.lsb_first <= RST_BREAK_LINE[LINE_ORDER_BIT];
            s_q.tx_inv    <= RST_BREAK_LINE[LINE_INVERT_BIT];
            s_q.input_switch_control       <= RST_INPUT_SWITCH[1:0];
            s_q.port_dir  <= RST_PORT4_DIR[PORT4_PINS-1:0];
            s_q.rx_st     <= RX_IDLE;
            s_q.tx_st     <= TX_IDLE;
            s_q.tx_line   <= 1'b1;
            s_q.rx_line   <= 1'b1;
            s_q.unit_rst  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign O_RDATA           = s_q.rdata;
    assign O_SERIAL_TX_LINE  = s_q.tx_line;
    assign O_RX_LINE         = s_q.rx_line;
    assign O_UNIT_CLK_EN     = s_q.clk_en;
    assign O_UNIT_RESET      = s_q.unit_rst;
    assign O_TX_RUN          = s_q.tx_run;
    assign O_RX_RUN          = s_q.rx_run;
    assign O_LSB_FIRST       = s_q.lsb_out;
    assign O_MODE            = s_q.mode;
    assign O_TX_COMPLETE_IRQ = s_q.tx_done;
    assign O_BREAK_RX_DONE   = s_q.rx_done;
    assign O_BREAK_RX_ERR    = s_q.rx_err;
    assign O_EXT_IRQ_IN      = s_q.ext_irq;
    assign O_CAPTURE_IN      = s_q.capture;
    assign O_PORT_OE         = s_q.port_oe;

    // ========================================================================
    // Checks.
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    chk_line_reset: assert property ($past(I_RESET) && !I_RESET |->
        s_q.brk_len == 3'b101 && s_q.lsb_first && !s_q.tx_inv
        && !s_q.tx_trig && !s_q.rx_trig && s_q.mode == 8'h01)
        else $error("control registers not at reset values");
    chk_trig_read_zero: assert property (I_ADDR == ADDR_BREAK_LINE |=>
        O_RDATA[6:5] == 2'b00
        && O_RDATA[7] == $past(s_q.rx_status))
        else $error("break register read wrong");
    chk_tx_break_end: assert property (s_q.tx_st == TX_LOW && tx_tick
        && !tx_restart && s_q.mode[7] && s_q.mode[6]
        && s_q.tx_cnt == brk_len_bits(s_q.brk_len) - 5'h01 |=>
        s_q.tx_st == TX_IDLE && O_TX_COMPLETE_IRQ && !s_q.tx_trig)
        else $error("break transmit did not end at its length");
    chk_tx_break_low: assert property (s_q.tx_st == TX_LOW
        && s_q.mode[7] && s_q.mode[6] |=>
        O_SERIAL_TX_LINE == $past(s_q.tx_inv))
        else $error("break not driven active");
    chk_power_off_lines: assert property (!s_q.mode[7] |=>
        O_SERIAL_TX_LINE && O_RX_LINE && !O_UNIT_CLK_EN)
        else $error("power off did not force lines high");
    chk_power_off_clear: assert property (!s_q.mode[7] && !rx_restart |=>
        !s_q.rx_status && !s_q.rx_trig)
        else $error("power off did not clear break status");
    chk_enable_reset: assert property (!s_q.mode[6] |=>
        s_q.tx_st == TX_IDLE)
        else $error("transmit disable did not reset break");
    chk_rx_success: assert property (s_q.rx_st == RX_LOW
        && s_q.mode[7] && s_q.mode[5] && !rx_restart && I_RX_PIN
        && s_q.rx_cnt >= BRK_MIN_BITS |=> !s_q.rx_status
        && !s_q.rx_trig && O_BREAK_RX_DONE)
        else $error("good break did not clear status");
    chk_port_dir: assert property (1'b1 |=>
        O_PORT_OE == ~$past(s_q.port_dir))
        else $error("port buffer enable does not follow direction");
    chk_rx_route: assert property (s_q.input_switch_control[0] |=>
        O_EXT_IRQ_IN == $past(I_RX_PIN))
        else $error("receive pin not routed to interrupt input");
    chk_bit_order: assert property (1'b1 |=>
        O_LSB_FIRST == $past(s_q.lsb_first))
        else $error("bit order output wrong");

    cov_tx_break: cover property (s_q.tx_st == TX_LOW ##1
        O_TX_COMPLETE_IRQ);
    cov_rx_done: cover property (O_BREAK_RX_DONE);
    cov_rx_err: cover property (O_BREAK_RX_ERR);
endmodule
`default_nettype wire

// >>> tb/ubs_lin_node.sv
// Remote serial node model: drives the receive pin, times transmit breaks.
// Assumes one clock shared with the unit and a pulled-up receive line.
`default_nettype none
module ubs_lin_node (
    input  wire logic i_clk,
    input  wire logic i_tx_line,
    output logic      o_rx_line
);
    timeunit 1ns;
    timeprecision 1ps;

    int low_run;
    int last_low;

    initial begin
        o_rx_line = 1'b1;
        low_run   = 0;
        last_low  = 0;
    end

    // ========================================================================
    // Length of each low stretch on the transmit line, in clocks.
    always @(posedge i_clk) begin
        if (i_tx_line === 1'b0) begin
            low_run++;
        end else if (low_run != 0) begin
            last_low = low_run;
            low_run  = 0;
        end
    end

    // ========================================================================
    // Holds the line low for whole bit times, then drives it back high.
    task automatic send_low(input int bits, input int bt);
        @(posedge i_clk);
        o_rx_line <= 1'b0;
        repeat (bits * bt) @(posedge i_clk);
        o_rx_line <= 1'b1;
    endtask
endmodule
`default_nettype wire

// >>> tb/ubs_ctrl_tb_top.sv
// Self-checking bench for the serial break and stop control block.
// Assumes the remote node model and a 25 MHz clock.
`default_nettype none
module ubs_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ubs_pkg::*;

    // Short bit time keeps every break field to a few dozen clocks.
    localparam int BK = 2;
    localparam int BT = 2 * BK;

    logic        I_CLK = 1'b0;
    logic        I_RESET = 1'b1;
    logic [15:0] I_ADDR = 16'h0000;
    logic        I_WR = 1'b0;
    logic [7:0]  I_WDATA = 8'h00;
    logic        I_SHIFT_TXD = 1'b1;
    logic        I_EXT_IRQ_PIN = 1'b0;
    logic        I_CAPTURE_PIN = 1'b0;
    wire logic   rx_pin;
    logic [7:0]  O_RDATA;
    logic        O_SERIAL_TX_LINE;
    logic        O_RX_LINE;
    logic        O_UNIT_CLK_EN;
    logic        O_UNIT_RESET;
    logic        O_TX_RUN;
    logic        O_RX_RUN;
    logic        O_LSB_FIRST;
    logic [7:0]  O_MODE;
    logic        O_TX_COMPLETE_IRQ;
    logic        O_BREAK_RX_DONE;
    logic        O_BREAK_RX_ERR;
    logic        O_EXT_IRQ_IN;
    logic        O_CAPTURE_IN;
    logic [5:0]  O_PORT_OE;
    int          mismatches = 0;
    int          n_checks = 0;
    int          cnt[3] = '{0, 0, 0};

    always #20 I_CLK = ~I_CLK;

    ubs_ctrl #(.BAUD_K(BK)) ubs_ctrl_inst (
        .I_CLK(I_CLK), .I_RESET(I_RESET), .I_ADDR(I_ADDR), .I_WR(I_WR),
        .I_WDATA(I_WDATA), .I_RX_PIN(rx_pin), .I_SHIFT_TXD(I_SHIFT_TXD),
        .I_EXT_IRQ_PIN(I_EXT_IRQ_PIN), .I_CAPTURE_PIN(I_CAPTURE_PIN),
        .O_RDATA(O_RDATA), .O_SERIAL_TX_LINE(O_SERIAL_TX_LINE),
        .O_RX_LINE(O_RX_LINE), .O_UNIT_CLK_EN(O_UNIT_CLK_EN),
        .O_UNIT_RESET(O_UNIT_RESET), .O_TX_RUN(O_TX_RUN),
        .O_RX_RUN(O_RX_RUN), .O_LSB_FIRST(O_LSB_FIRST), .O_MODE(O_MODE),
        .O_TX_COMPLETE_IRQ(O_TX_COMPLETE_IRQ),
        .O_BREAK_RX_DONE(O_BREAK_RX_DONE), .O_BREAK_RX_ERR(O_BREAK_RX_ERR),
        .O_EXT_IRQ_IN(O_EXT_IRQ_IN), .O_CAPTURE_IN(O_CAPTURE_IN),
        .O_PORT_OE(O_PORT_OE)
    );

    ubs_lin_node ubs_lin_node_inst (
        .i_clk(I_CLK), .i_tx_line(O_SERIAL_TX_LINE), .o_rx_line(rx_pin)
    );

    // ========================================================================
    // Event counters for the one-cycle completion pulses.
    always @(posedge I_CLK) begin
        if (O_TX_COMPLETE_IRQ === 1'b1) cnt[0]++;
        if (O_BREAK_RX_DONE === 1'b1) cnt[1]++;
        if (O_BREAK_RX_ERR === 1'b1) cnt[2]++;
    end

    // ========================================================================
    // Shared tasks.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h, expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge I_CLK);
        I_ADDR <= a;
        I_WR <= 1'b1;
        I_WDATA <= d;
        @(posedge I_CLK);
        I_WR <= 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge I_CLK);
        I_ADDR <= a;
        @(posedge I_CLK);
        #1;
        chk(16'(O_RDATA), 16'(e));
    endtask

    task automatic settle();
        repeat (3) @(posedge I_CLK);
        #1;
    endtask

    // A lost pulse would otherwise hang, so the wait is bounded.
    task automatic wait_evt(input int k);
        int c0;
        int i;
        c0 = cnt[k];
        i = 0;
        while (cnt[k] == c0 && i < 400) begin
            @(posedge I_CLK);
            i++;
        end
        settle();
        chk(16'(cnt[k] - c0), 16'h0001);
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ========================================================================
    // Scenarios.
    task automatic t_reset();
        rd_chk(ADDR_PORT4_DIR, 8'hFF);
        rd_chk(ADDR_MODE_CTRL, 8'h01);
        rd_chk(ADDR_BREAK_LINE, 8'h16);
        rd_chk(ADDR_INPUT_SWITCH, 8'h00);
        rd_chk(16'hFF91, 8'h00);
        chk(16'(O_PORT_OE), 16'h0000);
        chk(16'({O_UNIT_RESET, O_SERIAL_TX_LINE, O_LSB_FIRST}),
            16'h0007);
    endtask

    task automatic t_ports_switch();
        wr(ADDR_PORT4_DIR, 8'h17);
        rd_chk(ADDR_PORT4_DIR, 8'hD7);
        chk(16'(O_PORT_OE), 16'h0028);
        wr(ADDR_INPUT_SWITCH, 8'h01);
        settle();
        chk(16'({O_EXT_IRQ_IN, O_CAPTURE_IN}), 16'h0002);
        wr(ADDR_INPUT_SWITCH, 8'h02);
        settle();
        chk(16'({O_EXT_IRQ_IN, O_CAPTURE_IN}), 16'h0001);
        wr(ADDR_INPUT_SWITCH, 8'h03);
    endtask

    task automatic t_power_up();
        wr(ADDR_MODE_CTRL, 8'h80);
        wr(ADDR_MODE_CTRL, 8'hE0);
        settle();
        chk(16'(O_MODE), 16'h00E0);
        chk(16'({O_TX_RUN, O_RX_RUN, O_UNIT_CLK_EN, O_UNIT_RESET}),
            16'h000E);
    endtask

    task automatic t_break_tx();
        int n;
        for (int c = 0; c < 8; c++) begin
            n = 13 + ((c + 3) % 8);
            wr(ADDR_BREAK_LINE, {3'b001, 3'(c), 2'b10});
            rd_chk(ADDR_BREAK_LINE, {3'b000, 3'(c), 2'b10});
            wait_evt(0);
            chk(16'((ubs_lin_node_inst.last_low + BT / 2) / BT),
                16'(n));
        end
        // A second trigger mid-break starts the count again from zero.
        // The wait is trimmed so the retrigger lands five bit times in.
        wr(ADDR_BREAK_LINE, 8'h36);
        repeat (5 * BT - 2) @(posedge I_CLK);
        wr(ADDR_BREAK_LINE, 8'h36);
        wait_evt(0);
        chk(16'((ubs_lin_node_inst.last_low + BT / 2) / BT),
            16'h0012);
    endtask

    task automatic t_order_invert();
        wr(ADDR_MODE_CTRL, 8'h80);
        settle();
        chk(16'({O_TX_RUN, O_RX_RUN, O_UNIT_CLK_EN}), 16'h0001);
        wr(ADDR_BREAK_LINE, 8'h15);
        wr(ADDR_MODE_CTRL, 8'hE0);
        I_SHIFT_TXD <= 1'b0;
        settle();
        chk(16'(O_LSB_FIRST), 16'h0000);
        chk(16'(O_SERIAL_TX_LINE), 16'h0001);
        I_SHIFT_TXD <= 1'b1;
        settle();
        chk(16'(O_SERIAL_TX_LINE), 16'h0000);
        wr(ADDR_MODE_CTRL, 8'h80);
        wr(ADDR_BREAK_LINE, 8'h16);
        wr(ADDR_MODE_CTRL, 8'hE0);
        settle();
        chk(16'({O_LSB_FIRST, O_SERIAL_TX_LINE}), 16'h0003);
    endtask

    task automatic t_break_rx();
        wr(ADDR_BREAK_LINE, 8'h56);
        rd_chk(ADDR_BREAK_LINE, 8'h96);
        ubs_lin_node_inst.send_low(5, BT);
        wait_evt(2);
        rd_chk(ADDR_BREAK_LINE, 8'h96);
        wr(ADDR_BREAK_LINE, 8'h56);
        ubs_lin_node_inst.send_low(13, BT);
        wait_evt(1);
        rd_chk(ADDR_BREAK_LINE, 8'h16);
    endtask

    task automatic t_power_off();
        wr(ADDR_BREAK_LINE, 8'h56);
        wr(ADDR_MODE_CTRL, 8'h80);
        wr(ADDR_MODE_CTRL, 8'h00);
        fork
            ubs_lin_node_inst.send_low(6, BT);
        join_none
        repeat (4) @(posedge I_CLK);
        #1;
        chk(16'({O_RX_LINE, O_SERIAL_TX_LINE}), 16'h0003);
        chk(16'(O_EXT_IRQ_IN), 16'h0000);
        chk(16'({O_UNIT_RESET, O_UNIT_CLK_EN}), 16'h0002);
        chk(16'(O_MODE), 16'h0000);
        rd_chk(ADDR_BREAK_LINE, 8'h16);
        repeat (8 * BT) @(posedge I_CLK);
    endtask

    // ========================================================================
    // Main sequence and watchdog.
    initial begin
        repeat (12) @(posedge I_CLK);
        I_RESET <= 1'b0;
        t_reset();
        t_ports_switch();
        t_power_up();
        t_break_tx();
        t_order_invert();
        t_break_rx();
        t_power_off();
        wrap_up();
    end

    initial begin
        #(40 * 20000);
        mismatches++;
        wrap_up();
    end
endmodule
`default_nettype wire
